// file: verilog/bridge_regs_map.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Definitions only
`ifndef BRIDGE_REGS_MAP_SVH
`define BRIDGE_REGS_MAP_SVH

// ==========================================================
// Register byte addresses
`define OFF_STATUS      8'h50
`define OFF_CONFIG      8'h54
`define OFF_CTRL        8'h58
`define OFF_IRQ_STATUS  8'h5c
`define OFF_IRQ_MASK    8'h60

// ==========================================================
// Status register fields
`define STS_INIT_DONE   4
`define STS_CFG_DONE    2
`define STS_SUM_PASS    1
`define STS_RESET       8'h02

// ==========================================================
// Config register fields
`define CFG_BPP_HI      5
`define CFG_BPP_LO      4
`define CFG_AUDIO_TDM   2
`define CFG_AUDIO_MODE  1
`define CFG_AUX_AUDIO   0
`define CFG_RESET       8'h02
`define CFG_WMASK       8'h37

// ==========================================================
// Control register fields
`define CTL_CFG_INIT    0
`define CTL_PORT_SEL    1
`define CTL_INDEP       2
`define CTL_CONT_CLK    3

// ==========================================================
// Interrupt event bits
`define EVT_CFG_DONE    0
`define EVT_INIT_DONE   1
`define EVT_SUM_FAIL    2
`define EVT_W           3

// ==========================================================
// Bytes-per-pixel codes and quarter-byte counts
`define BPP_3           2'h0
`define BPP_2P25        2'h1
`define BPP_2           2'h2
`define BPP_RSVD        2'h3
`define QB_3            4'hc
`define QB_2P25         4'h9
`define QB_2            4'h8

// ==========================================================
// Non-volatile memory layout
`define NVM_CFG_ADDR    8'h00
`define NVM_SUM_BYTES   128

`endif

// file: verilog/bridge_regs_pkg.sv
// Purpose: Types shared by the bridge register bank
// Assumes: Constants live in bridge_regs_map.svh
// Notes:   Types only
package bridge_regs_pkg;

	// ==========================================================
	// Non-volatile memory walk states
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_LOAD,
		ST_LOAD_CAP,
		ST_SUM,
		ST_DRAIN
	} walk_state_e;

endpackage

// file: verilog/nvm_load_check.sv
// Purpose: Loads the config byte and checks the tail checksum of NVM
// Assumes: Synchronous NVM, data valid the cycle after the read edge
// Notes:   Checksum passes when the byte sum is zero modulo 256
`include "bridge_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module nvm_load_check #(
	parameter int ADDR_W = 8,
	parameter int DEPTH  = 256
) (
	input  wire logic              hclk,        // System clock
	input  wire logic              hresetn,     // Async reset, low
	input  wire logic              start,       // Begin load and check
	output logic [ADDR_W-1:0]      nvm_addr,    // NVM read address
	output logic                   nvm_rd_en,   // NVM read strobe
	input  wire logic [7:0]        nvm_rd_data, // NVM read data
	output logic                   cfg_valid,   // Config byte pulse
	output logic [7:0]             cfg_byte,    // Loaded config byte
	output logic                   check_done,  // Checksum finished pulse
	output logic                   sum_ok       // Checksum passed
);

	localparam int CNT_W = $clog2(`NVM_SUM_BYTES + 1);
	localparam logic [ADDR_W-1:0] SUM_BASE =
		ADDR_W'(DEPTH - `NVM_SUM_BYTES);
	localparam logic [CNT_W-1:0] SUM_LAST = CNT_W'(`NVM_SUM_BYTES);

	// ==========================================================
	// Elaboration checks
	initial
	begin
		if (DEPTH < `NVM_SUM_BYTES + 1 || DEPTH > (1 << ADDR_W))
			$error("nvm_load_check: DEPTH does not fit");
	end

	bridge_regs_pkg::walk_state_e state_q;
	logic [CNT_W-1:0]             issued_q;
	logic                         rd_d1_q;
	logic [7:0]                   acc_q;

	// ==========================================================
	// Walk: config byte first, then tail bytes summed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q    <= bridge_regs_pkg::ST_IDLE;
			nvm_addr   <= '0;
			nvm_rd_en  <= 1'b0;
			rd_d1_q    <= 1'b0;
			issued_q   <= '0;
			acc_q      <= 8'h00;
			cfg_valid  <= 1'b0;
			cfg_byte   <= 8'h00;
			check_done <= 1'b0;
			sum_ok     <= 1'b1;
		end
		else
		begin
			cfg_valid  <= 1'b0;
			check_done <= 1'b0;
			rd_d1_q    <= nvm_rd_en;
			if (rd_d1_q && state_q != bridge_regs_pkg::ST_LOAD_CAP)
				acc_q <= acc_q + nvm_rd_data;
			case (state_q)
				bridge_regs_pkg::ST_IDLE:
				begin
					if (start)
					begin
						nvm_addr  <= ADDR_W'(`NVM_CFG_ADDR);
						nvm_rd_en <= 1'b1;
						state_q   <= bridge_regs_pkg::ST_LOAD;
					end
				end
				bridge_regs_pkg::ST_LOAD:
				begin
					nvm_rd_en <= 1'b0;
					state_q   <= bridge_regs_pkg::ST_LOAD_CAP;
				end
				bridge_regs_pkg::ST_LOAD_CAP:
				begin
					cfg_byte  <= nvm_rd_data;
					cfg_valid <= 1'b1;
					acc_q     <= 8'h00;
					nvm_addr  <= SUM_BASE;
					nvm_rd_en <= 1'b1;
					issued_q  <= CNT_W'(1);
					state_q   <= bridge_regs_pkg::ST_SUM;
				end
				bridge_regs_pkg::ST_SUM:
				begin
					if (issued_q == SUM_LAST)
					begin
						nvm_rd_en <= 1'b0;
						state_q   <= bridge_regs_pkg::ST_DRAIN;
					end
					else
					begin
						nvm_addr <= nvm_addr + ADDR_W'(1);
						issued_q <= issued_q + CNT_W'(1);
					end
				end
				bridge_regs_pkg::ST_DRAIN:
				begin
					if (!rd_d1_q)
					begin
						sum_ok     <= (acc_q == 8'h00);
						check_done <= 1'b1;
						state_q    <= bridge_regs_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_q <= bridge_regs_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule // nvm_load_check

`default_nettype wire

// file: verilog/bridge_regs.sv
// Purpose: Bridge status and config registers on AHB-Lite
// Assumes: Single word transfers, one clock, NVM on the same clock
// Notes:   Zero wait states; every answer is OKAY
//
// Behaviour
// - Config-done flag sets after config load
// - Verify checksum over last 128 NVM bytes
// - Checksum pass bit read-only, resets to one
// - Bytes-per-pixel code: 3, 2.25, 2 bytes
// - Three and two byte settings cover formats
// - RGB converts to 24-bit, others pass through
// - Independent mode: field addresses selected port
// - TDM enable serializes audio onto first line
// - Audio source select, resets to one
// - Auxiliary two-channel audio enable, resets zero
// - Continuous clock: clock lane always high-speed
// - Config-init reloads NVM, self-clears when done
`include "bridge_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_regs #(
	parameter int NVM_ADDR_W = 8,
	parameter int NVM_DEPTH  = 256
) (
	input  wire logic                  hclk,          // Bus clock
	input  wire logic                  hresetn,       // Async reset, low
	input  wire logic                  hsel,          // Slave select
	input  wire logic [31:0]           haddr,         // Byte address
	input  wire logic [1:0]            htrans,        // Transfer type
	input  wire logic                  hwrite,        // Write when high
	input  wire logic [2:0]            hsize,         // Transfer size
	input  wire logic [31:0]           hwdata,        // Write data
	input  wire logic                  hready,        // Bus ready in
	output logic [31:0]                hrdata,        // Read data
	output logic                       hreadyout,     // Slave ready
	output logic                       hresp,         // Always OKAY
	output logic                       irq,           // Level interrupt
	output logic [NVM_ADDR_W-1:0]      nvm_addr,      // NVM address
	output logic                       nvm_rd_en,     // NVM read strobe
	input  wire logic [7:0]            nvm_rd_data,   // NVM read data
	input  wire logic                  strap_cont_clk,// Strap pin
	input  wire logic [1:0]            fmt_is_rgb,    // Per-port RGB type
	output logic [3:0]                 bpp_qb_first,  // Port 0 quarter B
	output logic [3:0]                 bpp_qb_second, // Port 1 quarter B
	output logic [1:0]                 rgb_to_24,     // Per-port expand
	output logic                       hs_clock_lane, // Clock lane in HS
	output logic                       audio_send,    // Audio downstream
	output logic                       tdm_first_line,// Serialize audio
	output logic                       aux_audio_on   // Aux audio stream
);

	// ==========================================================
	// Elaboration checks
	initial
	begin
		if (NVM_ADDR_W < 8 || NVM_ADDR_W > 16)
			$error("bridge_regs: NVM_ADDR_W out of range");
	end

	// Config reset word, named so its fields can be picked out
	localparam logic [7:0] CFG_RST = `CFG_RESET;

	// ==========================================================
	// Quarter-byte count of a bytes-per-pixel code
	function automatic logic [3:0] bpp_quarters(input logic [1:0] code);
		logic [3:0] q;
		q = `QB_3;
		if (code == `BPP_2P25)
			q = `QB_2P25;
		else if (code == `BPP_2)
			q = `QB_2;
		return q;
	endfunction

	// ==========================================================
	// Register state
	logic [1:0]           strap_s1_q;
	logic                 strap_s2_q;
	logic                 cfg_done_q;
	logic                 init_done_q;
	logic                 cfg_init_q;
	logic                 powerup_q;
	logic                 port_sel_q;
	logic                 indep_q;
	logic                 cont_clk_q;
	logic [1:0]           bpp_first_q;
	logic [1:0]           bpp_second_q;
	logic                 audio_tdm_q;
	logic                 audio_mode_q;
	logic                 aux_audio_q;
	logic [`EVT_W-1:0]    evt_sts_q;
	logic [`EVT_W-1:0]    evt_mask_q;
	logic                 wr_pend_q;
	logic [7:0]           wr_addr_q;

	// ==========================================================
	// Loader wires
	logic                 walk_start;
	logic                 cfg_valid;
	logic [7:0]           cfg_byte;
	logic                 check_done;
	logic                 sum_ok;

	// ==========================================================
	// Strap synchronizer, three flops, third stage only is read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_s1_q <= 2'h0;
			strap_s2_q <= 1'b0;
		end
		else
		begin
			strap_s1_q <= {strap_s1_q[0], strap_cont_clk};
			strap_s2_q <= strap_s1_q[1];
		end
	end

	// ==========================================================
	// Address phase decode
	wire        addr_ph   = hsel && hready && htrans[1];
	wire        rd_req    = addr_ph && !hwrite;
	wire        wr_req    = addr_ph && hwrite;
	wire [7:0]  a_lo      = haddr[7:0];
	wire        a_hi_zero = (haddr[31:8] == 24'h000000);

	// Data phase write strobes
	wire        wr_sts    = wr_pend_q && wr_addr_q == `OFF_STATUS;
	wire        wr_cfg    = wr_pend_q && wr_addr_q == `OFF_CONFIG;
	wire        wr_ctl    = wr_pend_q && wr_addr_q == `OFF_CTRL;
	wire        wr_isr    = wr_pend_q && wr_addr_q == `OFF_IRQ_STATUS;
	wire        wr_imr    = wr_pend_q && wr_addr_q == `OFF_IRQ_MASK;

	// ==========================================================
	// Field selection for the shared bytes-per-pixel slot
	wire        sel_second = indep_q && port_sel_q;
	wire [1:0]  bpp_view   = sel_second ? bpp_second_q : bpp_first_q;
	wire [1:0]  bpp_wr     = hwdata[`CFG_BPP_HI:`CFG_BPP_LO];
	wire        bpp_wr_ok  = wr_cfg && bpp_wr != `BPP_RSVD;

	// ==========================================================
	// Read views, reserved bits zero
	wire [7:0]  sts_view = {3'h0, init_done_q, 1'b0, cfg_done_q,
		sum_ok, 1'b0};
	wire [7:0]  cfg_view = {2'h0, bpp_view, 1'b0, audio_tdm_q,
		audio_mode_q, aux_audio_q};
	wire [7:0]  ctl_view = {4'h0, cont_clk_q, indep_q, port_sel_q,
		cfg_init_q};
	wire [7:0]  isr_view = {{(8-`EVT_W){1'b0}}, evt_sts_q};
	wire [7:0]  imr_view = {{(8-`EVT_W){1'b0}}, evt_mask_q};

	// ==========================================================
	// Read data mux, unmapped reads give zero
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		if (!a_hi_zero)
			rd_mux = 8'h00;
		else if (a_lo == `OFF_STATUS)
			rd_mux = sts_view;
		else if (a_lo == `OFF_CONFIG)
			rd_mux = cfg_view;
		else if (a_lo == `OFF_CTRL)
			rd_mux = ctl_view;
		else if (a_lo == `OFF_IRQ_STATUS)
			rd_mux = isr_view;
		else if (a_lo == `OFF_IRQ_MASK)
			rd_mux = imr_view;
	end

	// ==========================================================
	// Bus slave: zero wait, OKAY, read data for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= wr_req && a_hi_zero;
			wr_addr_q <= a_lo;
			if (rd_req)
				hrdata <= {24'h000000, rd_mux};
		end
	end

	// ==========================================================
	// Sequence start: power-up once, or config-init write
	wire init_wr   = wr_ctl && hwdata[`CTL_CFG_INIT] && !cfg_init_q;
	assign walk_start = powerup_q || init_wr;

	// ==========================================================
	// Load and checksum engine
	nvm_load_check #(
		.ADDR_W (NVM_ADDR_W),
		.DEPTH  (NVM_DEPTH)
	) u_loader (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.start       (walk_start),
		.nvm_addr    (nvm_addr),
		.nvm_rd_en   (nvm_rd_en),
		.nvm_rd_data (nvm_rd_data),
		.cfg_valid   (cfg_valid),
		.cfg_byte    (cfg_byte),
		.check_done  (check_done),
		.sum_ok      (sum_ok)
	);

	// ==========================================================
	// Power-up sequence flags
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			powerup_q   <= 1'b1;
			cfg_done_q  <= 1'b0;
			init_done_q <= 1'b0;
			cfg_init_q  <= 1'b0;
		end
		else
		begin
			powerup_q <= 1'b0;
			if (walk_start)
			begin
				cfg_done_q  <= 1'b0;
				init_done_q <= 1'b0;
			end
			if (cfg_valid)
				cfg_done_q <= 1'b1;
			if (check_done && cfg_done_q)
				init_done_q <= 1'b1;
			if (init_wr)
				cfg_init_q <= 1'b1;
			else if (check_done)
				cfg_init_q <= 1'b0;
		end
	end

	// ==========================================================
	// Control register: port select, mode, strapped clock mode
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_sel_q <= 1'b0;
			indep_q    <= 1'b0;
			cont_clk_q <= 1'b0;
		end
		else if (cfg_valid)
			cont_clk_q <= strap_s2_q;
		else if (wr_ctl)
		begin
			port_sel_q <= hwdata[`CTL_PORT_SEL];
			indep_q    <= hwdata[`CTL_INDEP];
			cont_clk_q <= hwdata[`CTL_CONT_CLK];
		end
	end

	// ==========================================================
	// Config register: NVM load, then host writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bpp_first_q  <= `BPP_3;
			bpp_second_q <= `BPP_3;
			audio_tdm_q  <= CFG_RST[`CFG_AUDIO_TDM];
			audio_mode_q <= CFG_RST[`CFG_AUDIO_MODE];
			aux_audio_q  <= CFG_RST[`CFG_AUX_AUDIO];
		end
		else if (cfg_valid)
		begin
			if (cfg_byte[`CFG_BPP_HI:`CFG_BPP_LO] != `BPP_RSVD)
			begin
				bpp_first_q  <= cfg_byte[`CFG_BPP_HI:`CFG_BPP_LO];
				bpp_second_q <= cfg_byte[`CFG_BPP_HI:`CFG_BPP_LO];
			end
			audio_tdm_q  <= cfg_byte[`CFG_AUDIO_TDM];
			audio_mode_q <= cfg_byte[`CFG_AUDIO_MODE];
			aux_audio_q  <= cfg_byte[`CFG_AUX_AUDIO];
		end
		else if (wr_cfg)
		begin
			if (bpp_wr_ok && sel_second)
				bpp_second_q <= bpp_wr;
			else if (bpp_wr_ok)
				bpp_first_q <= bpp_wr;
			audio_tdm_q  <= hwdata[`CFG_AUDIO_TDM];
			audio_mode_q <= hwdata[`CFG_AUDIO_MODE];
			aux_audio_q  <= hwdata[`CFG_AUX_AUDIO];
		end
	end

	// ==========================================================
	// Interrupt events: set wins over write-one-to-clear
	wire [`EVT_W-1:0] evt_set;
	assign evt_set[`EVT_CFG_DONE]  = cfg_valid;
	assign evt_set[`EVT_INIT_DONE] = check_done && cfg_done_q;
	assign evt_set[`EVT_SUM_FAIL]  = check_done && !sum_ok;
	wire [`EVT_W-1:0] evt_clr =
		wr_isr ? hwdata[`EVT_W-1:0] : {`EVT_W{1'b0}};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			evt_sts_q  <= {`EVT_W{1'b0}};
			evt_mask_q <= {`EVT_W{1'b0}};
			irq        <= 1'b0;
		end
		else
		begin
			evt_sts_q <= (evt_sts_q & ~evt_clr) | evt_set;
			if (wr_imr)
				evt_mask_q <= hwdata[`EVT_W-1:0];
			irq <= |(((evt_sts_q & ~evt_clr) | evt_set) & evt_mask_q);
		end
	end

	// ==========================================================
	// Downstream controls, all registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bpp_qb_first   <= `QB_3;
			bpp_qb_second  <= `QB_3;
			rgb_to_24      <= 2'h0;
			hs_clock_lane  <= 1'b0;
			audio_send     <= 1'b0;
			tdm_first_line <= 1'b0;
			aux_audio_on   <= 1'b0;
		end
		else
		begin
			bpp_qb_first   <= bpp_quarters(bpp_first_q);
			bpp_qb_second  <= bpp_quarters(indep_q ?
				bpp_second_q : bpp_first_q);
			rgb_to_24      <= fmt_is_rgb;
			hs_clock_lane  <= cont_clk_q;
			audio_send     <= audio_mode_q;
			tdm_first_line <= audio_mode_q && audio_tdm_q;
			aux_audio_on   <= aux_audio_q;
		end
	end


endmodule // bridge_regs

`default_nettype wire

// file: verif/nvm_model.sv
// Purpose: Synchronous NVM seen by the config loader
// Assumes: Data out the cycle after the read edge
// Notes:   Bench fills mem directly; idle output toggles
`timescale 1ns/1ps
`default_nettype none

module nvm_model #(
	parameter int ADDR_W = 8,
	parameter int DEPTH  = 256
) (
	input  wire logic              clk,     // Bus clock
	input  wire logic              rd_en,   // Read strobe
	input  wire logic [ADDR_W-1:0] addr,    // Read address
	output logic [7:0]             rd_data  // Read data
);
	// ====================
	// Storage and read port
	logic [7:0] mem [DEPTH];
	initial
		rd_data = 8'h00;
	// Idle data toggles so a stale byte never looks valid
	always @(posedge clk)
		if (rd_en)
			rd_data <= mem[addr];
		else
			rd_data <= ~rd_data;
endmodule // nvm_model
`default_nettype wire

// file: verif/bridge_regs_chk_assertions.sv
// Purpose: Port assertions for the bridge register bank
// Assumes: One clock, async active-low reset
// Notes:   Bound to every bridge_regs instance
`include "bridge_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_regs_chk #(
	parameter int NVM_ADDR_W = 8,
	parameter int NVM_DEPTH  = 256
) (
	input wire logic                  hclk,           // Clock
	input wire logic                  hresetn,        // Reset, low
	input wire logic                  hsel,           // Select
	input wire logic [31:0]           haddr,          // Address
	input wire logic [1:0]            htrans,         // Transfer type
	input wire logic                  hwrite,         // Write
	input wire logic                  hready,         // Bus ready
	input wire logic [31:0]           hrdata,         // Read data
	input wire logic                  hreadyout,      // Slave ready
	input wire logic                  hresp,          // Response
	input wire logic                  irq,            // Interrupt
	input wire logic [NVM_ADDR_W-1:0] nvm_addr,       // NVM address
	input wire logic                  nvm_rd_en,      // NVM strobe
	input wire logic [1:0]            fmt_is_rgb,     // RGB flags
	input wire logic [3:0]            bpp_qb_first,   // Port 0 size
	input wire logic [3:0]            bpp_qb_second,  // Port 1 size
	input wire logic [1:0]            rgb_to_24,      // Expand flags
	input wire logic                  audio_send,     // Audio on
	input wire logic                  tdm_first_line  // TDM on
);
	localparam int TAIL = NVM_DEPTH - 128;
	localparam int LAST = NVM_DEPTH - 1;
	// ====================
	// Read data phase tracking
	logic       rd_q;
	logic [7:0] ra_q;
	logic       sts_rd;
	logic       cfg_rd;
	assign sts_rd = rd_q && ra_q == `OFF_STATUS;
	assign cfg_rd = rd_q && ra_q == `OFF_CONFIG;
	// Remembers a read address phase
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			rd_q <= 1'b0;
			ra_q <= 8'h00;
		end
		else
		begin
			rd_q <= hsel && hready && htrans[1] && !hwrite;
			ra_q <= haddr[7:0];
		end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====================
	// Properties
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	property p_bpp_first;
		bpp_qb_first inside {4'hc, 4'h9, 4'h8};
	endproperty
	property p_bpp_second;
		bpp_qb_second inside {4'hc, 4'h9, 4'h8};
	endproperty
	property p_tdm;
		tdm_first_line |-> audio_send;
	endproperty
	property p_rgb;
		$changed(fmt_is_rgb) |=> rgb_to_24 == $past(fmt_is_rgb);
	endproperty
	property p_nvm_range;
		nvm_rd_en |-> nvm_addr == 0 || nvm_addr >= TAIL;
	endproperty
	property p_nvm_step;
		nvm_rd_en && nvm_addr >= TAIL && nvm_addr < LAST
			|=> nvm_rd_en && nvm_addr == $past(nvm_addr) + 1'b1;
	endproperty
	property p_sts_rsvd;
		sts_rd |-> (hrdata & 32'hffffffe9) == 32'h0;
	endproperty
	property p_cfg_rsvd;
		cfg_rd |-> (hrdata & 32'hffffffc8) == 32'h0;
	endproperty
	property p_init_order;
		sts_rd && hrdata[`STS_INIT_DONE] |-> hrdata[`STS_CFG_DONE];
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus answer not ready or not okay");
	a_bpp_first: assert property (p_bpp_first)
		else $error("first port byte count illegal");
	a_bpp_second: assert property (p_bpp_second)
		else $error("second port byte count illegal");
	a_tdm: assert property (p_tdm)
		else $error("tdm active while audio off");
	a_rgb: assert property (p_rgb)
		else $error("rgb expand flag did not follow");
	a_nvm_range: assert property (p_nvm_range)
		else $error("nvm read outside config and tail");
	a_nvm_step: assert property (p_nvm_step)
		else $error("nvm tail walk skipped or stalled");
	a_sts_rsvd: assert property (p_sts_rsvd)
		else $error("status reserved bits set");
	a_cfg_rsvd: assert property (p_cfg_rsvd)
		else $error("config reserved bits set");
	a_init_order: assert property (p_init_order)
		else $error("init done without config done");
	c_init: cover property (sts_rd && hrdata[`STS_INIT_DONE]);
	c_irq: cover property (irq);
	c_tdm: cover property (tdm_first_line);
	c_step: cover property (nvm_rd_en && nvm_addr == LAST);
endmodule // bridge_regs_chk

bind bridge_regs bridge_regs_chk #(
	.NVM_ADDR_W(NVM_ADDR_W),
	.NVM_DEPTH(NVM_DEPTH)
) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.nvm_addr(nvm_addr), .nvm_rd_en(nvm_rd_en),
	.fmt_is_rgb(fmt_is_rgb), .bpp_qb_first(bpp_qb_first),
	.bpp_qb_second(bpp_qb_second), .rgb_to_24(rgb_to_24),
	.audio_send(audio_send), .tdm_first_line(tdm_first_line)
);
`default_nettype wire

// file: verif/tb_bridge_status_and_config_regs.sv
// Purpose: Self-checking bench for the bridge register bank
// Assumes: Zero-wait AHB-Lite slave, NVM model on the same clock
// Notes:   Config expectation kept in a bench model, status checked against constants
`include "bridge_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_bridge_status_and_config_regs;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w;
	logic [1:0] htrans = 2'h0, fmt_is_rgb = 2'h0, rgb_to_24;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq, nvm_rd_en, strap_cont_clk = 1'b0;
	logic hs_clock_lane, audio_send, tdm_first_line, aux_audio_on;
	logic [7:0] nvm_addr, nvm_rd_data;
	logic [3:0] bpp_qb_first, bpp_qb_second;
	logic [31:0] cfg_m;
	int num_errors = 0;
	int n_tests = 0;
	always #20 hclk = ~hclk;
	bridge_regs #(.NVM_ADDR_W(8), .NVM_DEPTH(256)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.nvm_addr(nvm_addr), .nvm_rd_en(nvm_rd_en),
		.nvm_rd_data(nvm_rd_data), .strap_cont_clk(strap_cont_clk),
		.fmt_is_rgb(fmt_is_rgb), .bpp_qb_first(bpp_qb_first),
		.bpp_qb_second(bpp_qb_second), .rgb_to_24(rgb_to_24),
		.hs_clock_lane(hs_clock_lane), .audio_send(audio_send),
		.tdm_first_line(tdm_first_line), .aux_audio_on(aux_audio_on)
	);
	nvm_model #(.ADDR_W(8), .DEPTH(256)) u_nvm (
		.clk(hclk), .rd_en(nvm_rd_en), .addr(nvm_addr),
		.rd_data(nvm_rd_data)
	);
	// ====================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] a, input logic wr,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int k;
		k = 0;
		do
		begin
			xfer(a, 1'b0, 32'h0);
			k++;
		end
		while (rd[b] !== v && k < 400);
	endtask
	task automatic settle;
		repeat (2) @(posedge hclk);
	endtask
	// Tail bytes sum to zero modulo 256 unless a fault is wanted
	task automatic load_nvm(input bit good);
		logic [7:0] s;
		s = 8'h00;
		u_nvm.mem[0] = 8'h25;
		for (int i = 128; i < 255; i++)
		begin
			u_nvm.mem[i] = 8'($urandom);
			s += u_nvm.mem[i];
		end
		u_nvm.mem[255] = 8'h00 - s + {7'h0, !good};
	endtask
	function automatic logic [31:0] qb(input logic [1:0] c);
		return c == 2'h0 ? 32'hc : c == 2'h1 ? 32'h9 : 32'h8;
	endfunction
	// ====================
	// Main sequence
	initial
	begin
		void'($urandom(2819));
		load_nvm(1'b1);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(`OFF_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h02);
		poll(`OFF_STATUS, `STS_INIT_DONE, 1'b1);
		chk(rd, 32'h16);
		cfg_m = 32'h25;
		xfer(`OFF_CONFIG, 1'b0, 32'h0);
		chk(rd, cfg_m);
		for (int c = 0; c < 4; c++)
		begin
			w = $urandom;
			w[5:4] = 2'(c);
			xfer(`OFF_CONFIG, 1'b1, w);
			cfg_m = c == 3 ? (w & 32'h07) | (cfg_m & 32'h30) : w & 32'h37;
			xfer(`OFF_CONFIG, 1'b0, 32'h0);
			chk(rd, cfg_m);
			settle;
			chk(bpp_qb_first, qb(cfg_m[5:4]));
			chk({audio_send, tdm_first_line, aux_audio_on},
				{cfg_m[1], cfg_m[1] & cfg_m[2], cfg_m[0]});
		end
		xfer(`OFF_CTRL, 1'b1, 32'h06);
		xfer(`OFF_CONFIG, 1'b1, 32'h20);
		settle;
		chk(bpp_qb_second, 32'h8);
		chk(bpp_qb_first, qb(cfg_m[5:4]));
		xfer(`OFF_CTRL, 1'b1, 32'h00);
		settle;
		chk(bpp_qb_second, qb(cfg_m[5:4]));
		xfer(8'h70, 1'b1, 32'hff);
		xfer(8'h70, 1'b0, 32'h0);
		chk(rd, 32'h0);
		// Interrupt raised, masked, cleared
		xfer(`OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h3);
		chk(irq, 32'h0);
		xfer(`OFF_IRQ_MASK, 1'b1, 32'h2);
		settle;
		chk(irq, 32'h1);
		xfer(`OFF_IRQ_STATUS, 1'b1, 32'h2);
		settle;
		chk(irq, 32'h0);
		xfer(`OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h1);
		// Reload with a bad checksum and the strap raised
		load_nvm(1'b0);
		strap_cont_clk <= 1'b1;
		xfer(`OFF_CTRL, 1'b1, 32'h01);
		poll(`OFF_CTRL, `CTL_CFG_INIT, 1'b0);
		chk(rd[`CTL_CFG_INIT], 32'h0);
		poll(`OFF_STATUS, `STS_INIT_DONE, 1'b1);
		chk(rd, 32'h14);
		xfer(`OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk(rd, 32'h7);
		xfer(`OFF_CONFIG, 1'b0, 32'h0);
		chk(rd, 32'h25);
		chk(hs_clock_lane, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			w = $urandom;
			fmt_is_rgb <= w[1:0];
			repeat (2) @(posedge hclk);
			chk(rgb_to_24, w[1:0]);
		end
		summarize;
	end
	// Two NVM walks plus bus traffic need well under this span
	initial
	begin
		#2000000;
		num_errors++;
		summarize;
	end
endmodule // tb_bridge_status_and_config_regs
`default_nettype wire
